// *** logic/wdcm_defs.vh ***
// constants shared by the watchdog and clock monitor block
`ifndef WDCM_DEFS_VH
`define WDCM_DEFS_VH

// ==========================================================================
// register indices (byte address is four times the index)
// ==========================================================================
`define WDCM_IDX_OPTIONS 16'h1039
`define WDCM_IDX_SERVICE 16'h103A
`define WDCM_IDX_TEST 16'h103E
`define WDCM_IDX_CONFIG 16'h103F
`define WDCM_IDX_IRQ_STATUS 16'h1040
`define WDCM_IDX_IRQ_CLEAR 16'h1041
`define WDCM_IDX_IRQ_ENABLE 16'h1042
`define WDCM_IDX_STATE 16'h1043

// ==========================================================================
// system options fields
// ==========================================================================
`define WDCM_OPT_CONVERTER_POWER_UP 7
`define WDCM_OPT_CONVERTER_CLOCK_SELECT 6
`define WDCM_OPT_IRQ_EDGE_SELECT 5
`define WDCM_OPT_OSCILLATOR_DELAY_ENABLE 4
`define WDCM_OPT_CLOCK_MONITOR_ENABLE 3
`define WDCM_OPT_RATE_HI 1
`define WDCM_OPT_RATE_LO 0
`define WDCM_OPTIONS_RESET 8'h10
`define WDCM_OPT_ONCE_MASK 8'h33
`define WDCM_OPT_ANYTIME_MASK 8'hC8

// ==========================================================================
// configuration and test control fields
// ==========================================================================
`define WDCM_CFG_WATCHDOG_DISABLE_BIT 2
`define WDCM_CFG_PROGRAM_MEMORY_ENABLE 1
`define WDCM_CFG_NONVOLATILE_MEMORY_ENABLE 0
`define WDCM_CFG_MASK 8'h07
`define WDCM_CONFIG_RESET 8'h03
`define WDCM_TEST_DISABLE_RESETS_BIT 0

// ==========================================================================
// service keys
// ==========================================================================
`define WDCM_KEY_ARM 8'h55
`define WDCM_KEY_CLEAR 8'hAA

// ==========================================================================
// interrupt status bits
// ==========================================================================
`define WDCM_IRQ_WATCHDOG_TIMEOUT 0
`define WDCM_IRQ_CLOCK_FAIL 1
`define WDCM_IRQ_SERVICE_DONE 2
`define WDCM_IRQ_EXTERNAL_RESET 3
`define WDCM_IRQ_BITS 4

// ==========================================================================
// timing, in bus clock cycles; the rate factors count prescaler periods
// ==========================================================================
`define WDCM_PRESCALE_DIV 32768
`define WDCM_ONCE_WINDOW 7'd64
`define WDCM_RATE_F0 7'd1
`define WDCM_RATE_F1 7'd4
`define WDCM_RATE_F2 7'd16
`define WDCM_RATE_F3 7'd64
`define WDCM_RST_DRIVE_CYC 3'd4
`define WDCM_RST_SAMPLE_CYC 3'd2

// reset cause codes
`define WDCM_CAUSE_NONE 2'h0
`define WDCM_CAUSE_WATCHDOG 2'h1
`define WDCM_CAUSE_CLOCK 2'h2
`define WDCM_CAUSE_EXTERNAL 2'h3

`endif

// *** logic/wdcm_reset_seq.v ***
// reset pin sequencer: drives the pin, then tells internal from external reset
`timescale 1ns/1ps
`default_nettype none
`include "wdcm_defs.vh"

module wdcm_reset_seq (
   input wire clk_sys_in,
   input wire rst_n_in,
   input wire start_in,
   input wire reset_pin_in,
   output wire reset_pin_out,
   output wire reset_pin_oe_out,
   output wire busy_out,
   output reg done_out,
   output reg external_out
);
   // ======================================================================
   // states
   // ======================================================================
   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_DRIVE = 4'h2;
   localparam [3:0] ST_WAIT = 4'h4;
   localparam [3:0] ST_EXT = 4'h8;

   reg [3:0] state_ff;
   reg [2:0] cnt_ff;

   // open drain: only ever pulls low
   assign reset_pin_out = 1'b0;
   assign reset_pin_oe_out = state_ff[1];
   assign busy_out = ~state_ff[0];

   // ======================================================================
   // sequence
   // ======================================================================
   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_ff <= ST_IDLE;
         cnt_ff <= 3'h0;
         done_out <= 1'b0;
         external_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         case (state_ff)
            ST_IDLE: begin
               cnt_ff <= 3'h0;
               if (start_in) begin
                  state_ff <= ST_DRIVE;
               end else if (!reset_pin_in) begin
                  state_ff <= ST_EXT;
               end
            end
            ST_DRIVE: begin
               if (cnt_ff == `WDCM_RST_DRIVE_CYC - 3'd1) begin
                  cnt_ff <= 3'h0;
                  state_ff <= ST_WAIT;
               end else begin
                  cnt_ff <= cnt_ff + 3'd1;
               end
            end
            ST_WAIT: begin
               if (cnt_ff == `WDCM_RST_SAMPLE_CYC - 3'd1) begin
                  if (!reset_pin_in) begin
                     state_ff <= ST_EXT;
                  end else begin
                     external_out <= 1'b0;
                     done_out <= 1'b1;
                     state_ff <= ST_IDLE;
                  end
               end else begin
                  cnt_ff <= cnt_ff + 3'd1;
               end
            end
            ST_EXT: begin
               // a pin still low after our release belongs to someone else
               if (reset_pin_in) begin
                  external_out <= 1'b1;
                  done_out <= 1'b1;
                  state_ff <= ST_IDLE;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // wdcm_reset_seq

`default_nettype wire

// *** logic/wdcm_top.v ***
// watchdog timer, clock monitor and system options registers behind APB
//
// Functional notes
// - watchdog_disable_bit 0 enables the watchdog reset, 1 disables it.
// - watchdog disable change applies only after the next system reset; memory enables apply at once.
// - special modes start with disable_resets_bit set; writing 0 permits watchdog resets.
// - timeout is clock over 2^15 times factor 1, 4, 16 or 64.
// - rate select resets to zero; normal mode allows one write in 64 cycles.
// - irq edge, oscillator delay, rate bits write-once early; free in special modes.
// - writing 55 then AA to the service register clears the counter.
// - armed state survives other activity until the AA write.
// - timeout without completed service starts a system reset.
// - enabled clock monitor resets when the RC delay passes without clock.
// - clock monitor timing comes from the RC cell, not any clock.
// - watchdog counter halts when clocks stop; no timeout then.
// - monitor trips below 10 kHz, never at 200 kHz or above.
// - entering stop mode with clock monitor enabled produces a reset.
// - clock monitor enable is read/write anytime, cleared by reset.
// - irq edge select 0 gives level, 1 gives edge-only interrupt.
// - internal reset drives the pin low 4 cycles, samples 2 later.
`timescale 1ns/1ps
`default_nettype none
`include "wdcm_defs.vh"

module wdcm_top #(
   parameter PRESCALE_DIV = `WDCM_PRESCALE_DIV,
   parameter [7:0] CONFIG_DEFAULT = `WDCM_CONFIG_RESET
) (
   input wire clk_sys_in,
   input wire rst_n_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [31:0] paddr_in,
   input wire [31:0] pwdata_in,
   output wire [31:0] prdata_out,
   output wire pready_out,
   output wire pslverr_out,
   input wire special_mode_in,
   input wire stop_mode_in,
   input wire rc_expired_in,
   input wire reset_pin_in,
   output wire reset_pin_out,
   output wire reset_pin_oe_out,
   output wire system_reset_out,
   input wire irq_n_in,
   input wire irq_ack_in,
   output wire irq_request_out,
   output wire converter_power_up_out,
   output wire converter_clock_select_out,
   output wire oscillator_delay_enable_out,
   output wire program_memory_enable_out,
   output wire nonvolatile_memory_enable_out,
   output wire interrupt_out
);
   // prescaler must divide by at least two
   localparam PRESCALE_W = $clog2(PRESCALE_DIV);
   localparam integer PRESCALE_LAST_INT = PRESCALE_DIV - 1;
   localparam [PRESCALE_W-1:0] PRESCALE_LAST = PRESCALE_LAST_INT[PRESCALE_W-1:0];

   // ======================================================================
   // decode helpers
   // ======================================================================
   function addr_hit;
      input [31:0] addr;
      input [15:0] idx;
      begin
         addr_hit = (addr == {14'h0000, idx, 2'b00});
      end
   endfunction

   function [6:0] rate_factor;
      input [1:0] sel;
      begin
         case (sel)
            2'b00: rate_factor = `WDCM_RATE_F0;
            2'b01: rate_factor = `WDCM_RATE_F1;
            2'b10: rate_factor = `WDCM_RATE_F2;
            default: rate_factor = `WDCM_RATE_F3;
         endcase
      end
   endfunction

   // ======================================================================
   // declarations
   // ======================================================================
   reg init_ff;
   reg special_mode_ff;
   reg wd_enable_ff;
   reg disable_resets_ff;
   reg [7:0] config_ff;
   reg [7:0] options_ff;
   reg once_locked_ff;
   reg [6:0] win_cnt_ff;
   reg [PRESCALE_W-1:0] prescale_ff;
   reg [6:0] wd_count_ff;
   reg armed_ff;
   reg [1:0] cause_ff;
   reg [`WDCM_IRQ_BITS-1:0] irq_status_ff;
   reg [`WDCM_IRQ_BITS-1:0] irq_enable_ff;
   reg [31:0] prdata_ff;
   reg pslverr_ff;
   reg irq_prev_n_ff;
   reg irq_edge_ff;
   reg irq_req_ff;
   reg [31:0] nxt_rdata;
   reg nxt_mapped;
   reg [`WDCM_IRQ_BITS-1:0] nxt_irq_status;
   wire setup;
   wire wr;
   wire load_strap;
   wire reinit;
   wire window_open;
   wire once_ok;
   wire tick;
   wire wd_trip;
   wire wd_reset_req;
   wire cm_fail;
   wire seq_start;
   wire seq_busy;
   wire seq_done;
   wire seq_external;
   wire service_arm;
   wire service_done;

   // ======================================================================
   // APB slave: zero wait states, read data captured in the setup cycle
   // ======================================================================
   assign setup = psel_in & ~penable_in;
   assign wr = psel_in & penable_in & pwrite_in;
   assign pready_out = 1'b1;
   assign prdata_out = prdata_ff;
   assign pslverr_out = pslverr_ff & psel_in & penable_in;

   always @* begin
      nxt_rdata = 32'h0000_0000;
      nxt_mapped = 1'b1;
      if (addr_hit(paddr_in, `WDCM_IDX_OPTIONS)) begin
         nxt_rdata[7:0] = options_ff;
      end else if (addr_hit(paddr_in, `WDCM_IDX_SERVICE)) begin
         nxt_rdata = 32'h0000_0000;
      end else if (addr_hit(paddr_in, `WDCM_IDX_TEST)) begin
         nxt_rdata[`WDCM_TEST_DISABLE_RESETS_BIT] = disable_resets_ff;
      end else if (addr_hit(paddr_in, `WDCM_IDX_CONFIG)) begin
         nxt_rdata[7:0] = config_ff;
      end else if (addr_hit(paddr_in, `WDCM_IDX_IRQ_STATUS)) begin
         nxt_rdata[`WDCM_IRQ_BITS-1:0] = irq_status_ff;
      end else if (addr_hit(paddr_in, `WDCM_IDX_IRQ_CLEAR)) begin
         nxt_rdata = 32'h0000_0000;
      end else if (addr_hit(paddr_in, `WDCM_IDX_IRQ_ENABLE)) begin
         nxt_rdata[`WDCM_IRQ_BITS-1:0] = irq_enable_ff;
      end else if (addr_hit(paddr_in, `WDCM_IDX_STATE)) begin
         nxt_rdata[25:24] = cause_ff;
         nxt_rdata[16] = special_mode_ff;
         nxt_rdata[15] = armed_ff;
         nxt_rdata[14] = wd_enable_ff;
         nxt_rdata[13] = window_open;
         nxt_rdata[12] = once_locked_ff;
         nxt_rdata[6:0] = wd_count_ff;
      end else begin
         nxt_mapped = 1'b0;
      end
   end

   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prdata_ff <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else if (setup) begin
         prdata_ff <= pwrite_in ? 32'h0000_0000 : nxt_rdata;
         pslverr_ff <= ~nxt_mapped;
      end
   end

   // ======================================================================
   // strap capture and internal reinitialisation
   // ======================================================================
   // straps are taken by a clocked process after release, never by the reset
   assign load_strap = init_ff | seq_done;
   assign reinit = seq_done;

   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         init_ff <= 1'b1;
         special_mode_ff <= 1'b0;
         wd_enable_ff <= 1'b0;
         disable_resets_ff <= 1'b0;
      end else begin
         init_ff <= 1'b0;
         if (load_strap) begin
            special_mode_ff <= special_mode_in;
            wd_enable_ff <= ~config_ff[`WDCM_CFG_WATCHDOG_DISABLE_BIT];
            disable_resets_ff <= special_mode_in;
         end else if (wr && special_mode_ff && addr_hit(paddr_in, `WDCM_IDX_TEST)) begin
            disable_resets_ff <= pwdata_in[`WDCM_TEST_DISABLE_RESETS_BIT];
         end
      end
   end

   // survives internal resets so a new enable state can reach the next one
   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         config_ff <= CONFIG_DEFAULT & `WDCM_CFG_MASK;
      end else if (wr && addr_hit(paddr_in, `WDCM_IDX_CONFIG)) begin
         config_ff <= pwdata_in[7:0] & `WDCM_CFG_MASK;
      end
   end

   // ======================================================================
   // system options with the early write-once window
   // ======================================================================
   assign window_open = win_cnt_ff < `WDCM_ONCE_WINDOW;
   assign once_ok = special_mode_ff | (window_open & ~once_locked_ff);

   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         win_cnt_ff <= 7'h00;
      end else if (reinit) begin
         win_cnt_ff <= 7'h00;
      end else if (window_open) begin
         win_cnt_ff <= win_cnt_ff + 7'h01;
      end
   end

   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         options_ff <= `WDCM_OPTIONS_RESET;
         once_locked_ff <= 1'b0;
      end else if (reinit) begin
         options_ff <= `WDCM_OPTIONS_RESET;
         once_locked_ff <= 1'b0;
      end else if (wr && addr_hit(paddr_in, `WDCM_IDX_OPTIONS)) begin
         // bit 2 is unimplemented and stays zero through both masks
         if (once_ok) begin
            options_ff <= pwdata_in[7:0] & (`WDCM_OPT_ONCE_MASK | `WDCM_OPT_ANYTIME_MASK);
            once_locked_ff <= ~special_mode_ff;
         end else begin
            options_ff <= (options_ff & `WDCM_OPT_ONCE_MASK) |
                          (pwdata_in[7:0] & `WDCM_OPT_ANYTIME_MASK);
         end
      end
   end

   assign converter_power_up_out = options_ff[`WDCM_OPT_CONVERTER_POWER_UP];
   assign converter_clock_select_out = options_ff[`WDCM_OPT_CONVERTER_CLOCK_SELECT];
   assign oscillator_delay_enable_out = options_ff[`WDCM_OPT_OSCILLATOR_DELAY_ENABLE];
   assign program_memory_enable_out = config_ff[`WDCM_CFG_PROGRAM_MEMORY_ENABLE];
   assign nonvolatile_memory_enable_out = config_ff[`WDCM_CFG_NONVOLATILE_MEMORY_ENABLE];

   // ======================================================================
   // watchdog prescaler, counter and service keys
   // ======================================================================
   // stop mode stands for the halted clock: the prescaler and watchdog counter do not advance then
   assign tick = (prescale_ff == PRESCALE_LAST) & ~stop_mode_in;
   assign service_arm = wr & addr_hit(paddr_in, `WDCM_IDX_SERVICE) &
                        (pwdata_in[7:0] == `WDCM_KEY_ARM);
   assign service_done = wr & addr_hit(paddr_in, `WDCM_IDX_SERVICE) &
                         (pwdata_in[7:0] == `WDCM_KEY_CLEAR) & armed_ff;
   // one extra tick because the first one after a clear can come at once
   assign wd_trip = wd_enable_ff & tick & ~seq_busy &
                    (wd_count_ff == rate_factor(options_ff[1:0]));
   assign wd_reset_req = wd_trip & ~disable_resets_ff;

   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prescale_ff <= {PRESCALE_W{1'b0}};
      end else if (!stop_mode_in) begin
         // free running: a service does not realign it
         prescale_ff <= (prescale_ff == PRESCALE_LAST) ? {PRESCALE_W{1'b0}} :
                        prescale_ff + {{(PRESCALE_W-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wd_count_ff <= 7'h00;
      end else if (reinit || !wd_enable_ff || seq_busy || service_done || wd_trip) begin
         wd_count_ff <= 7'h00;
      end else if (tick) begin
         wd_count_ff <= wd_count_ff + 7'h01;
      end
   end

   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         armed_ff <= 1'b0;
      end else if (reinit || service_done) begin
         armed_ff <= 1'b0;
      end else if (service_arm) begin
         armed_ff <= 1'b1;
      end
   end

   // ======================================================================
   // clock monitor
   // ======================================================================
   // the RC cell times the clock gap on its own and reports a level; the
   // 10 kHz and 200 kHz limits are properties of that cell, not of this logic
   assign cm_fail = options_ff[`WDCM_OPT_CLOCK_MONITOR_ENABLE] &
                    (rc_expired_in | stop_mode_in);

   // ======================================================================
   // reset sequencing
   // ======================================================================
   // no start in the done cycle: the options are only reinitialised at its end
   assign seq_start = (wd_reset_req | cm_fail) & ~seq_busy & ~seq_done;
   assign system_reset_out = seq_busy;

   wdcm_reset_seq u_reset_seq (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .start_in(seq_start),
      .reset_pin_in(reset_pin_in),
      .reset_pin_out(reset_pin_out),
      .reset_pin_oe_out(reset_pin_oe_out),
      .busy_out(seq_busy),
      .done_out(seq_done),
      .external_out(seq_external)
   );

   // clock monitor wins over watchdog when both fire together
   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cause_ff <= `WDCM_CAUSE_NONE;
      end else if (seq_done && seq_external) begin
         cause_ff <= `WDCM_CAUSE_EXTERNAL;
      end else if (seq_start && cm_fail) begin
         cause_ff <= `WDCM_CAUSE_CLOCK;
      end else if (seq_start) begin
         cause_ff <= `WDCM_CAUSE_WATCHDOG;
      end
   end

   // ======================================================================
   // external interrupt conditioning
   // ======================================================================
   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_prev_n_ff <= 1'b1;
         irq_edge_ff <= 1'b0;
         irq_req_ff <= 1'b0;
      end else begin
         irq_prev_n_ff <= irq_n_in;
         if (irq_prev_n_ff && !irq_n_in) begin
            irq_edge_ff <= 1'b1; // set beats acknowledge
         end else if (irq_ack_in) begin
            irq_edge_ff <= 1'b0;
         end
         irq_req_ff <= options_ff[`WDCM_OPT_IRQ_EDGE_SELECT] ?
                       irq_edge_ff : ~irq_n_in;
      end
   end

   assign irq_request_out = irq_req_ff;

   // ======================================================================
   // interrupt status, clear and enable
   // ======================================================================
   always @* begin
      nxt_irq_status = irq_status_ff;
      if (wr && addr_hit(paddr_in, `WDCM_IDX_IRQ_CLEAR)) begin
         nxt_irq_status = nxt_irq_status & ~pwdata_in[`WDCM_IRQ_BITS-1:0];
      end
      // events after the clear so a coincident event survives it
      if (wd_trip) begin
         nxt_irq_status[`WDCM_IRQ_WATCHDOG_TIMEOUT] = 1'b1;
      end
      if (seq_start && cm_fail) begin
         nxt_irq_status[`WDCM_IRQ_CLOCK_FAIL] = 1'b1;
      end
      if (service_done) begin
         nxt_irq_status[`WDCM_IRQ_SERVICE_DONE] = 1'b1;
      end
      if (seq_done && seq_external) begin
         nxt_irq_status[`WDCM_IRQ_EXTERNAL_RESET] = 1'b1;
      end
   end

   // status and enable are kept over internal resets so the cause stays visible
   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_status_ff <= {`WDCM_IRQ_BITS{1'b0}};
         irq_enable_ff <= {`WDCM_IRQ_BITS{1'b0}};
      end else begin
         irq_status_ff <= nxt_irq_status;
         if (wr && addr_hit(paddr_in, `WDCM_IDX_IRQ_ENABLE)) begin
            irq_enable_ff <= pwdata_in[`WDCM_IRQ_BITS-1:0];
         end
      end
   end

   assign interrupt_out = |(irq_status_ff & irq_enable_ff);
endmodule // wdcm_top

`default_nettype wire

// *** sim/wdcm_properties.sv ***
// port assertions for the watchdog and clock monitor block
`timescale 1ns/1ps
`default_nettype none
module wdcm_checker (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic [31:0] paddr_in,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic reset_pin_in,
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe_out,
   input wire logic system_reset_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   wire logic acc = psel_in & penable_in;
   wire logic mapped = paddr_in inside {32'h40E4, 32'h40E8, 32'h40F8, 32'h40FC,
      32'h4100, 32'h4104, 32'h4108, 32'h410C};
   // ==========
   // reset pin sequence
   sequence s_drive;
      reset_pin_oe_out [*4] ##1 !reset_pin_oe_out;
   endsequence
   sequence s_pin_high;
      $fell(reset_pin_oe_out) ##0 reset_pin_in [*3];
   endsequence
   chk_drive_four: assert property ($rose(reset_pin_oe_out) |-> s_drive)
      else $error("pin drive not four cycles");
   chk_pin_low: assert property (reset_pin_oe_out |-> !reset_pin_out)
      else $error("pin driven high");
   chk_drive_in_reset: assert property (reset_pin_oe_out |-> system_reset_out)
      else $error("pin driven outside reset");
   chk_internal_release: assert property (s_pin_high |-> ##[0:3] !system_reset_out)
      else $error("reset not released with pin high");
   chk_external_hold: assert property (system_reset_out && !reset_pin_oe_out && !reset_pin_in
      |=> system_reset_out)
      else $error("reset ended while pin low");
   // ==========
   // bus answers
   chk_ready_high: assert property (pready_out)
      else $error("wait state seen");
   chk_err_unmapped: assert property (acc && !mapped |-> pslverr_out)
      else $error("unmapped access not refused");
   chk_err_idle: assert property (!acc |-> !pslverr_out)
      else $error("error outside access");
endmodule // wdcm_checker
bind wdcm_top wdcm_checker u_wdcm_checker (.clk_sys_in, .rst_n_in, .psel_in, .penable_in,
   .paddr_in, .pready_out, .pslverr_out, .reset_pin_in, .reset_pin_out, .reset_pin_oe_out,
   .system_reset_out);
`default_nettype wire

// *** sim/wdcm_top_tb.sv ***
// self-checking bench for the watchdog and clock monitor block
`timescale 1ns/1ps
`default_nettype none
module wdcm_top_tb;
   // short prescaler keeps timeouts to at most 1040 cycles
   localparam int P = 16;
   localparam logic [31:0] OPT = 32'h40E4, SVC = 32'h40E8, CFG = 32'h40FC, STA = 32'h4100;
   localparam logic [31:0] CLR = 32'h4104, ENA = 32'h4108, ST = 32'h410C;
   logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, stop = 0, rc = 0, ext = 1;
   logic prdy, oe, srst, intr;
   logic sp = 0, irqn = 1, ack = 0, ireq;
   logic [31:0] pa = 0, pd = 0, prd, r, m, v;
   int fail_count = 0, n_checks = 0, c;
   // open-drain pin: pulled up unless someone pulls it low
   wire logic pin = ext & ~oe;
   wdcm_top #(.PRESCALE_DIV(P)) u_wdcm_top (.clk_sys_in(clk), .rst_n_in(rst_n),
      .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pd),
      .prdata_out(prd), .pready_out(prdy), .pslverr_out(), .special_mode_in(sp),
      .stop_mode_in(stop), .rc_expired_in(rc), .reset_pin_in(pin), .reset_pin_out(),
      .reset_pin_oe_out(oe), .system_reset_out(srst), .irq_n_in(irqn), .irq_ack_in(ack),
      .irq_request_out(ireq), .converter_power_up_out(), .converter_clock_select_out(),
      .oscillator_delay_enable_out(), .program_memory_enable_out(),
      .nonvolatile_memory_enable_out(), .interrupt_out(intr));
   initial forever #50 clk = ~clk;
   // ==========
   // tasks
   task automatic chk(input string n, input logic [31:0] e, g);
      n_checks++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", n, e, g);
         fail_count++;
      end
   endtask
   task automatic xf(input logic w, input logic [31:0] a, d);
      @(posedge clk);
      psel <= 1; pen <= 0; pwr <= w; pa <= a; pd <= d;
      @(posedge clk);
      pen <= 1;
      do @(posedge clk); while (prdy !== 1);
      r = prd;
      psel <= 0; pen <= 0;
   endtask
   task automatic rd(input logic [31:0] a, e, input string n);
      xf(0, a, 0);
      chk(n, e, r);
   endtask
   task automatic wrst();
      c = 0;
      while (srst !== 1) begin @(negedge clk); c++; end
      while (srst !== 0) @(negedge clk);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #(8000 * 100);
      fail_count++;
      close_out();
   end
   // ==========
   // tests
   initial begin
      void'($urandom(32'h2E01CCCE));
      repeat (8) @(posedge clk);
      rst_n <= 1;
      v = ($urandom & 32'hF0) | 32'h3;
      xf(1, OPT, v);
      m = v;
      rd(OPT, m, "opt_first");
      v = $urandom & 32'hF0;
      xf(1, OPT, v);
      m = (v & 32'hC8) | (m & 32'h33);
      rd(OPT, m, "opt_locked");
      rd(32'h4000, 0, "unmapped");
      $display("options test done");
      xf(1, CLR, 32'hF); xf(1, ENA, 32'h4);
      xf(1, SVC, 32'h55); xf(1, SVC, 32'h12); xf(1, SVC, 32'hAA);
      @(negedge clk); chk("irq_on", 1, intr);
      rd(STA, 32'h4, "sta_svc");
      xf(1, CLR, 32'h4); xf(1, SVC, 32'hAA);
      @(negedge clk); chk("irq_off", 0, intr);
      rd(STA, 0, "sta_noarm");
      xf(1, ENA, 0); xf(1, SVC, 32'h55); xf(1, SVC, 32'hAA);
      @(negedge clk); chk("irq_mask", 0, intr);
      $display("service test done");
      xf(1, CFG, 32'h7);
      xf(0, ST, 0); chk("wd_still_on", 32'h4000, r & 32'h4000);
      for (int s = 0; s < 2; s++) begin
         xf(1, OPT, 32'h8);
         stop <= (s == 0); rc <= (s == 1);
         wrst();
         @(posedge clk);
         stop <= 0; rc <= 0;
         xf(0, ST, 0); chk("cm_cause", 2, r[25:24]);
         rd(OPT, 32'h10, "cme_cleared");
      end
      xf(0, ST, 0); chk("wd_off", 0, r & 32'h4000);
      // low pulse on the interrupt pin: level mode forgets it, edge mode keeps it
      for (int e = 0; e < 2; e++) begin
         irqn <= 0;
         repeat (3) @(posedge clk);
         irqn <= 1;
         repeat (3) @(posedge clk);
         @(negedge clk);
         chk("irq_mode", e, ireq);
         ack <= 1;
         xf(1, OPT, 32'h20);
         ack <= 0;
      end
      stop <= 1;
      repeat (60) @(posedge clk);
      stop <= 0;
      @(negedge clk);
      chk("stop_no_cme", 0, srst);
      ext <= 0;
      repeat (10) @(posedge clk);
      @(negedge clk);
      chk("ext_hold", 1, srst);
      ext <= 1;
      wrst();
      xf(0, ST, 0); chk("ext_cause", 3, r[25:24]);
      $display("clock monitor test done");
      xf(1, CFG, 32'h3); xf(1, OPT, 32'h8); rc <= 1;
      wrst();
      @(posedge clk);
      rc <= 0;
      for (int f = 0; f < 4; f++) begin
         xf(1, OPT, f);
         sp <= (f == 3);
         wrst();
         chk("wd_time", 1, c >= (P << 2 * f) - 8 && c <= (P << 2 * f) + P + 8);
         xf(0, ST, 0); chk("wd_cause", 1, r[25:24]);
      end
      $display("rate test done");
      xf(1, OPT, 32'h3); xf(1, OPT, 32'h1);
      rd(OPT, 32'h1, "opt_special");
      xf(1, CLR, 32'hF);
      c = 0;
      repeat (100) @(negedge clk) c += srst;
      chk("disable_resets_bit_hold", 0, c);
      rd(STA, 32'h1, "disable_resets_bit_status");
      xf(1, 32'h40F8, 0);
      wrst();
      xf(0, ST, 0); chk("disable_resets_bit_cause", 1, r[25:24]);
      $display("special mode test done");
      close_out();
   end
endmodule // wdcm_top_tb
`default_nettype wire
